/* File: design/lsip_port.sv */
// Purpose: Two-wire serial target port of an ambient light sensor.
// Assumes: Conversion inputs are on mclk; bus pins are asynchronous.
// Notes:   SDA is open drain; sda_oe high pulls the line low.
//
// What this block does
// - Combined mode, high fault: over set, under clear
// - Combined mode, low fault: under set, over clear
// - A finished conversion raises ready; interrupt in end-of-conversion mode, on a high fault, or on a latched low fault
// - Config read clears ready, and interrupt when latched or in end-of-conversion mode
// - Shutdown config write changes no status
// - Non-shutdown config write clears ready, and interrupt in transparent end-of-conversion mode
// - Alert response leaves status alone in transparent mode
// - Interrupt pin level follows state and polarity
// - First written byte loads the register pointer
// - Two data bytes, high first, each acknowledged
// - Reads use the last written pointer
// - Read returns high byte then low byte
// - Pointer kept across reads
// - Master code not acknowledged; filters go fast
// - Stop ends high-speed mode
// - General call then 06h resets all registers
// - Alert response answered only when latching
// - Alerting device acks and sends its address
// - Lost arbitration keeps interrupt; win clears it
// - Over-limit flag sent as address byte LSB
// - Alert response keeps both limit flags
// - Lower exponent top bits 11b enable end-of-conversion
// - Registers are sixteen bits, two bytes
`timescale 1ns/1ns
module lsip_port
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [6:0]  addr_strap,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_result,
  input  wire logic        fault_high,
  input  wire logic        fault_low,
  output logic             int_pin,
  output logic             hs_mode,
  output logic [15:0]      cfg_word,
  output logic [15:0]      low_limit,
  output logic [15:0]      high_limit
);

  lsip_line_if lines();

  lsip_line_rx u_line_rx
  (
    .mclk    (mclk),
    .reset_n (reset_n),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .lines   (lines)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  lsip_pkg::lsip_state_e state_reg;
  logic [2:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic        ack_on_reg;
  logic [1:0]  byte_idx_reg;
  logic        rw_reg;
  logic        gc_reg;
  logic        ara_reg;
  logic        mack_reg;
  logic        sda_oe_reg;
  logic        hs_reg;
  logic [7:0]  ptr_reg;
  logic [7:0]  wr_hi_reg;
  logic [6:0]  addr_s1_reg;
  logic [6:0]  addr_s2_reg;
  logic [15:0] cfg_reg;
  logic [15:0] cfg_next;
  logic [15:0] low_reg;
  logic [15:0] high_reg;
  logic [15:0] result_reg;
  logic        int_reg;
  logic        int_next;
  logic        int_pin_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  function automatic logic [15:0] read_mux(logic [7:0] ptr,
                                           logic [15:0] res,
                                           logic [15:0] cfg,
                                           logic [15:0] lo,
                                           logic [15:0] hi);
    unique case (ptr)
      lsip_pkg::PTR_RESULT: return res;
      lsip_pkg::PTR_CONFIG: return cfg;
      lsip_pkg::PTR_LOW:    return lo;
      lsip_pkg::PTR_HIGH:   return hi;
      lsip_pkg::PTR_MANUF:  return lsip_pkg::MANUF_ID;
      lsip_pkg::PTR_DEVID:  return lsip_pkg::DEVICE_ID;
      default:              return 16'h0000;
    endcase
  endfunction

  wire        in_addr  = (state_reg == lsip_pkg::ST_ADDR);
  wire        in_rx    = (state_reg == lsip_pkg::ST_RX);
  wire        in_tx    = (state_reg == lsip_pkg::ST_TX);
  wire        in_ack   = (state_reg == lsip_pkg::ST_ACK);
  wire [7:0]  rx_byte  = {shift_reg[6:0], lines.sda};
  wire        byte_in  = (in_addr | in_rx) & lines.scl_rise &
                         (bit_cnt_reg == 3'h7);
  wire        latched  = cfg_reg[lsip_pkg::CFG_L];
  wire        eoc_mode = (low_reg[lsip_pkg::EXP_TOP_HI:lsip_pkg::EXP_TOP_LO]
                          == lsip_pkg::EOC_CODE);
  wire        hit_dev  = (rx_byte[7:1] == addr_s2_reg);
  wire        is_gc    = (rx_byte == lsip_pkg::GC_ADDR);
  wire        is_ara   = (rx_byte[7:1] == lsip_pkg::ARA_ADDR) & rx_byte[0]
                         & latched & int_reg;
  wire        is_hs    = (rx_byte[7:3] == lsip_pkg::HS_CODE_TOP);
  wire        addr_ack = hit_dev | is_gc | is_ara;
  wire        gc_go    = gc_reg & (rx_byte == lsip_pkg::GC_RESET);
  wire        rx_ack   = gc_reg ? gc_go : 1'b1;
  wire        data_in  = byte_in & in_rx & ~gc_reg;
  wire        ptr_load = data_in & (byte_idx_reg == 2'h0);
  wire        wr_commit = data_in & (byte_idx_reg == 2'h2);
  wire [15:0] wr_word  = {wr_hi_reg, rx_byte};
  wire        gc_rst   = byte_in & in_rx & gc_go;
  wire        cfg_wr   = wr_commit & (ptr_reg == lsip_pkg::PTR_CONFIG);
  wire        cfg_run_wr = cfg_wr & (wr_word[lsip_pkg::CFG_M_HI:
                           lsip_pkg::CFG_M_LO] != lsip_pkg::M_SHUTDOWN);
  wire        ack_done = in_ack & lines.scl_fall & ack_on_reg;
  wire        ld_hi    = ack_done & rw_reg;
  wire        cfg_read = ld_hi & ~ara_reg &
                         (ptr_reg == lsip_pkg::PTR_CONFIG);
  wire [15:0] rd_word  = read_mux(ptr_reg, result_reg, cfg_reg, low_reg,
                                  high_reg);
  wire [7:0]  ara_byte = {addr_s2_reg,
                          cfg_reg[lsip_pkg::CFG_OVR]};
  wire [7:0]  tx_hi    = ara_reg ? ara_byte : rd_word[15:8];
  wire        ara_lost = in_tx & ara_reg & lines.scl_rise & ~sda_oe_reg &
                         ~lines.sda;
  wire        ara_win  = in_tx & ara_reg & lines.scl_fall &
                         (bit_cnt_reg == 3'h7);

  ////////////////////////////////////////////////////////////////////////////
  // Byte engine

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg    <= lsip_pkg::ST_IDLE;
      bit_cnt_reg  <= 3'h0;
      shift_reg    <= 8'h00;
      ack_on_reg   <= 1'b0;
      byte_idx_reg <= 2'h0;
      rw_reg       <= 1'b0;
      gc_reg       <= 1'b0;
      ara_reg      <= 1'b0;
      mack_reg     <= 1'b0;
      sda_oe_reg   <= 1'b0;
    end
    else if (lines.start)
    begin
      state_reg   <= lsip_pkg::ST_ADDR;
      bit_cnt_reg <= 3'h0;
      ack_on_reg  <= 1'b0;
      sda_oe_reg  <= 1'b0;
    end
    else if (lines.stop)
    begin
      state_reg  <= lsip_pkg::ST_IDLE;
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        lsip_pkg::ST_IDLE: ;
        lsip_pkg::ST_ADDR, lsip_pkg::ST_RX:
        begin
          if (lines.scl_rise)
          begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= 3'(bit_cnt_reg + 3'h1);
          end
          if (byte_in & in_addr)
          begin
            state_reg    <= addr_ack ? lsip_pkg::ST_ACK : lsip_pkg::ST_IDLE;
            rw_reg       <= rx_byte[0];
            gc_reg       <= ~hit_dev & is_gc;
            ara_reg      <= ~hit_dev & is_ara;
            byte_idx_reg <= 2'h0;
          end
          else if (byte_in)
          begin
            state_reg <= rx_ack ? lsip_pkg::ST_ACK : lsip_pkg::ST_IDLE;
            if (byte_idx_reg != 2'h3)
              byte_idx_reg <= 2'(byte_idx_reg + 2'h1);
          end
        end
        lsip_pkg::ST_ACK:
        begin
          if (lines.scl_fall & ~ack_on_reg)
          begin
            ack_on_reg <= 1'b1;
            sda_oe_reg <= 1'b1;
          end
          else if (ack_done)
          begin
            ack_on_reg  <= 1'b0;
            bit_cnt_reg <= 3'h0;
            state_reg   <= rw_reg ? lsip_pkg::ST_TX : lsip_pkg::ST_RX;
            shift_reg   <= tx_hi;
            sda_oe_reg  <= rw_reg & ~tx_hi[7];
          end
        end
        lsip_pkg::ST_TX:
        begin
          if (ara_lost)
          begin
            state_reg  <= lsip_pkg::ST_IDLE;
            sda_oe_reg <= 1'b0;
          end
          else if (lines.scl_fall & (bit_cnt_reg == 3'h7))
          begin
            state_reg  <= lsip_pkg::ST_MACK;
            sda_oe_reg <= 1'b0;
          end
          else if (lines.scl_fall)
          begin
            shift_reg   <= {shift_reg[6:0], 1'b0};
            sda_oe_reg  <= ~shift_reg[6];
            bit_cnt_reg <= 3'(bit_cnt_reg + 3'h1);
          end
        end
        lsip_pkg::ST_MACK:
        begin
          if (lines.scl_rise)
            mack_reg <= ~lines.sda;
          if (lines.scl_fall & mack_reg & ~ara_reg &
              (byte_idx_reg == 2'h0))
          begin
            state_reg    <= lsip_pkg::ST_TX;
            byte_idx_reg <= 2'h1;
            bit_cnt_reg  <= 3'h0;
            shift_reg    <= wr_hi_reg;
            sda_oe_reg   <= ~wr_hi_reg[7];
          end
          else if (lines.scl_fall)
            state_reg <= lsip_pkg::ST_IDLE;
        end
        default:
          state_reg <= lsip_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pointer, strap and high-speed mode

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ptr_reg     <= lsip_pkg::PTR_RESET;
      wr_hi_reg   <= 8'h00;
      addr_s1_reg <= 7'h00;
      addr_s2_reg <= 7'h00;
      hs_reg      <= 1'b0;
    end
    else
    begin
      addr_s1_reg <= addr_strap;
      addr_s2_reg <= addr_s1_reg;
      if (gc_rst)
        ptr_reg <= lsip_pkg::PTR_RESET;
      else if (ptr_load)
        ptr_reg <= rx_byte;
      if ((data_in & (byte_idx_reg == 2'h1)) | ld_hi)
        wr_hi_reg <= ld_hi ? rd_word[7:0] : rx_byte;
      if (lines.stop)
        hs_reg <= 1'b0;
      else if (byte_in & in_addr & is_hs & ~addr_ack)
        hs_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and interrupt; clears first so a same-cycle set wins

  always_comb
  begin
    cfg_next = cfg_reg;
    int_next = int_reg;
    if (cfg_wr)
      cfg_next = (cfg_reg & ~lsip_pkg::CFG_WR_MASK) |
                 (wr_word & lsip_pkg::CFG_WR_MASK);
    if (cfg_read)
    begin
      cfg_next[lsip_pkg::CFG_CRF] = 1'b0;
      if (eoc_mode)
        int_next = 1'b0;
      if (latched)
      begin
        cfg_next[lsip_pkg::CFG_OVR] = 1'b0;
        cfg_next[lsip_pkg::CFG_UND] = 1'b0;
        int_next = 1'b0;
      end
    end
    if (cfg_run_wr)
    begin
      cfg_next[lsip_pkg::CFG_CRF] = 1'b0;
      if (eoc_mode & ~latched)
        int_next = 1'b0;
    end
    if (ara_win)
      int_next = 1'b0;
    if (conv_done)
    begin
      cfg_next[lsip_pkg::CFG_CRF] = 1'b1;
      if (eoc_mode)
        int_next = 1'b1;
      if (fault_high)
      begin
        cfg_next[lsip_pkg::CFG_OVR] = 1'b1;
        if (~latched)
          cfg_next[lsip_pkg::CFG_UND] = 1'b0;
        int_next = 1'b1;
      end
      else if (fault_low)
      begin
        cfg_next[lsip_pkg::CFG_UND] = 1'b1;
        if (~latched)
          cfg_next[lsip_pkg::CFG_OVR] = 1'b0;
        int_next = latched | eoc_mode;
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_reg     <= lsip_pkg::CFG_RESET;
      low_reg     <= lsip_pkg::LOW_RESET;
      high_reg    <= lsip_pkg::HIGH_RESET;
      result_reg  <= lsip_pkg::RESULT_RESET;
      int_reg     <= 1'b0;
      int_pin_reg <= 1'b1;
    end
    else if (gc_rst)
    begin
      cfg_reg    <= lsip_pkg::CFG_RESET;
      low_reg    <= lsip_pkg::LOW_RESET;
      high_reg   <= lsip_pkg::HIGH_RESET;
      result_reg <= lsip_pkg::RESULT_RESET;
      int_reg    <= 1'b0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      int_reg <= int_next;
      if (conv_done)
        result_reg <= conv_result;
      if (wr_commit & (ptr_reg == lsip_pkg::PTR_LOW))
        low_reg <= wr_word;
      if (wr_commit & (ptr_reg == lsip_pkg::PTR_HIGH))
        high_reg <= wr_word;
      int_pin_reg <= int_reg ^ ~cfg_reg[lsip_pkg::CFG_IPL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign lines.hs_mode = hs_reg;
  assign hs_mode       = hs_reg;
  assign sda_out       = 1'b0;
  assign sda_oe        = sda_oe_reg;
  assign int_pin       = int_pin_reg;
  assign cfg_word      = cfg_reg;
  assign low_limit     = low_reg;
  assign high_limit    = high_reg;

endmodule // lsip_port

/* File: shared/lsip_pkg.sv */
// Purpose: Constants and types for the light sensor serial target port.
// Assumes: Block clock mclk at 100 MHz.
// Notes:   Register pointers, reset words, field positions, filter counts.
package lsip_pkg;

  // Glitch filter lengths on the bus lines
  localparam int CLK_NS       = 10;
  localparam int FS_SPIKE_NS  = 50;
  localparam int HS_SPIKE_NS  = 10;
  localparam int FS_FILT_CYC  = (FS_SPIKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HS_FILT_CYC  = (HS_SPIKE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] FS_FILT = 3'(FS_FILT_CYC);
  localparam logic [2:0] HS_FILT = 3'(HS_FILT_CYC);

  // Register pointers
  localparam logic [7:0] PTR_RESULT = 8'h00;
  localparam logic [7:0] PTR_CONFIG = 8'h01;
  localparam logic [7:0] PTR_LOW    = 8'h02;
  localparam logic [7:0] PTR_HIGH   = 8'h03;
  localparam logic [7:0] PTR_MANUF  = 8'h7e;
  localparam logic [7:0] PTR_DEVID  = 8'h7f;

  // Reset words
  localparam logic [15:0] CFG_RESET    = 16'hc810;
  localparam logic [15:0] LOW_RESET    = 16'h0000;
  localparam logic [15:0] HIGH_RESET   = 16'hffff;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [7:0]  PTR_RESET    = 8'h00;
  // Identity words: arbitrary values
  localparam logic [15:0] MANUF_ID     = 16'h5a5a;
  localparam logic [15:0] DEVICE_ID    = 16'h0a0a;

  // Configuration fields
  localparam int CFG_M_HI = 10;
  localparam int CFG_M_LO = 9;
  localparam int CFG_CRF  = 7;
  localparam int CFG_OVR  = 6;
  localparam int CFG_UND  = 5;
  localparam int CFG_L    = 4;
  localparam int CFG_IPL  = 3;
  localparam logic [15:0] CFG_WR_MASK = 16'hfe1f;
  localparam logic [1:0]  M_SHUTDOWN  = 2'b00;

  // Lower-limit exponent top bits select end-of-conversion signalling
  localparam int EXP_TOP_HI = 15;
  localparam int EXP_TOP_LO = 14;
  localparam logic [1:0] EOC_CODE = 2'b11;

  // Special bus addresses
  localparam logic [7:0] GC_ADDR     = 8'h00;
  localparam logic [7:0] GC_RESET    = 8'h06;
  localparam logic [6:0] ARA_ADDR    = 7'h0c;
  localparam logic [4:0] HS_CODE_TOP = 5'b00001;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK  = 3'b010,
    ST_RX   = 3'b011,
    ST_TX   = 3'b100,
    ST_MACK = 3'b101
  } lsip_state_e;

endpackage

/* File: shared/lsip_line_if.sv */
// Purpose: Filtered bus line events passed from the line receiver.
// Assumes: All signals on mclk.
// Notes:   hs_mode flows back to choose the filter length.
`timescale 1ns/1ns
interface lsip_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic hs_mode;

  modport rx  (output scl, sda, scl_rise, scl_fall, start, stop,
               input hs_mode);
  modport eng (input scl, sda, scl_rise, scl_fall, start, stop,
               output hs_mode);
endinterface

/* File: design/lsip_line_rx.sv */
// Purpose: Synchronise and filter the bus lines, find edges and conditions.
// Assumes: scl_in and sda_in are asynchronous pins.
// Notes:   Filter length shortens while high-speed mode is on.
`timescale 1ns/1ns
module lsip_line_rx
(
  input  wire logic  mclk,
  input  wire logic  reset_n,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  lsip_line_if.rx    lines
);

  logic       scl_s1_reg;
  logic       scl_s2_reg;
  logic       sda_s1_reg;
  logic       sda_s2_reg;
  logic       scl_f_reg;
  logic       sda_f_reg;
  logic       scl_p_reg;
  logic       sda_p_reg;
  logic [2:0] scl_cnt_reg;
  logic [2:0] sda_cnt_reg;
  logic [2:0] scl_cnt_next;
  logic [2:0] sda_cnt_next;
  logic [2:0] filt_len;

  function automatic logic [2:0] filt_step(logic raw, logic filt,
                                           logic [2:0] cnt);
    return (raw == filt) ? 3'h0 : 3'(cnt + 3'h1);
  endfunction

  assign filt_len     = lines.hs_mode ? lsip_pkg::HS_FILT
                                      : lsip_pkg::FS_FILT;
  assign scl_cnt_next = filt_step(scl_s2_reg, scl_f_reg, scl_cnt_reg);
  assign sda_cnt_next = filt_step(sda_s2_reg, sda_f_reg, sda_cnt_reg);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end
    else
    begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_f_reg   <= 1'b1;
      sda_f_reg   <= 1'b1;
      scl_p_reg   <= 1'b1;
      sda_p_reg   <= 1'b1;
      scl_cnt_reg <= 3'h0;
      sda_cnt_reg <= 3'h0;
    end
    else
    begin
      scl_p_reg   <= scl_f_reg;
      sda_p_reg   <= sda_f_reg;
      scl_cnt_reg <= (scl_cnt_next >= filt_len) ? 3'h0 : scl_cnt_next;
      sda_cnt_reg <= (sda_cnt_next >= filt_len) ? 3'h0 : sda_cnt_next;
      if (scl_cnt_next >= filt_len)
        scl_f_reg <= scl_s2_reg;
      if (sda_cnt_next >= filt_len)
        sda_f_reg <= sda_s2_reg;
    end
  end

  assign lines.scl      = scl_f_reg;
  assign lines.sda      = sda_f_reg;
  assign lines.scl_rise = scl_f_reg & ~scl_p_reg;
  assign lines.scl_fall = ~scl_f_reg & scl_p_reg;
  assign lines.start    = scl_f_reg & scl_p_reg & sda_p_reg & ~sda_f_reg;
  assign lines.stop     = scl_f_reg & scl_p_reg & ~sda_p_reg & sda_f_reg;

endmodule // lsip_line_rx

/* File: sim/lsip_port_properties.sv */
// Purpose: Port checks for the light sensor serial target port.
// Assumes: One clock domain, mclk; status seen through cfg_word.
// Notes:   st holds ready, over-limit and under-limit flags.
`timescale 1ns/1ns
module lsip_port_properties
(
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic [6:0]  addr_strap,
  input wire logic        conv_done,
  input wire logic [15:0] conv_result,
  input wire logic        fault_high,
  input wire logic        fault_low,
  input wire logic        int_pin,
  input wire logic        hs_mode,
  input wire logic [15:0] cfg_word,
  input wire logic [15:0] low_limit,
  input wire logic [15:0] high_limit
);
  wire       eoc = low_limit[15:14] == lsip_pkg::EOC_CODE;
  wire       lat = cfg_word[lsip_pkg::CFG_L];
  wire       irq_polarity_select = cfg_word[lsip_pkg::CFG_IPL];
  wire       te  = eoc && !lat;
  wire [2:0] st  = cfg_word[7:5];
  wire       cd  = conv_done;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  property p_high; cd && fault_high && te |=> st == 3'b110; endproperty
  a_high: assert property (p_high)
    else $error("high fault status wrong");
  property p_low;
    cd && !fault_high && fault_low && te |=> st == 3'b101;
  endproperty
  a_low: assert property (p_low)
    else $error("low fault status wrong");
  property p_none;
    cd && !fault_high && !fault_low && te
      |=> st[2] && st[1:0] == $past(st[1:0]);
  endproperty
  a_none: assert property (p_none)
    else $error("plain conversion status wrong");
  property p_crf; $rose(st[2]) |-> $past(cd); endproperty
  a_crf: assert property (p_crf)
    else $error("ready set without conversion");
  property p_pin; cd && te |-> ##3 int_pin == irq_polarity_select; endproperty
  a_pin: assert property (p_pin)
    else $error("interrupt pin level wrong");
  property p_eoc_off;
    cd && !fault_high && fault_low && !eoc && !lat |-> ##3 int_pin != irq_polarity_select;
  endproperty
  a_eoc_off: assert property (p_eoc_off)
    else $error("interrupt active without end of conversion");
  property p_flags;
    $changed(st[1:0]) |->
      $past(cd) || $past(lat) || cfg_word == lsip_pkg::CFG_RESET;
  endproperty
  a_flags: assert property (p_flags)
    else $error("flags changed without conversion");
  property p_hs_stop;
    hs_mode && scl_in && $rose(sda_in) |-> ##[1:12] !hs_mode;
  endproperty
  a_hs_stop: assert property (p_hs_stop)
    else $error("fast filters kept after stop");
  property p_hs_nak; $rose(hs_mode) |-> !sda_oe [*8]; endproperty
  a_hs_nak: assert property (p_hs_nak)
    else $error("master code acknowledged");

  c_high: cover property (cd && fault_high && te);
  c_hs_on: cover property ($rose(hs_mode));
  c_hs_off: cover property ($fell(hs_mode));
endmodule // lsip_port_properties

/* File: sim/lsip_bus_host.sv */
// Purpose: Bus host model that clocks the serial port bit by bit.
// Assumes: Open-drain data line with pull-up, resolved by the bench.
// Notes:   half is the SCL half period; a 1 bit releases the line.
`timescale 1ns/1ns
module lsip_bus_host
(
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  int half = 500;

  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic start();
    #(half / 2);
    sda_low = 1'b0;
    #(half / 2);
    scl = 1'b1;
    #(half / 2);
    sda_low = 1'b1;
    #(half / 2);
    scl = 1'b0;
  endtask

  task automatic stop();
    #(half / 2);
    sda_low = 1'b1;
    #(half / 2);
    scl = 1'b1;
    #(half / 2);
    sda_low = 1'b0;
    #(half * 2);
  endtask

  // Data changes only while SCL is low
  task automatic xfer(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--)
    begin
      #(half / 2);
      sda_low = ~w[i];
      #(half / 2);
      scl = 1'b1;
      #(half / 2);
      r[i] = sda;
      #(half / 2);
      scl = 1'b0;
    end
  endtask
endmodule // lsip_bus_host

/* File: sim/tb_lsip_port.sv */
// Purpose: Self-checking bench for the serial target port.
// Assumes: Host model drives the bus; bench drives conversion inputs.
// Notes:   F/S traffic runs at a 1 us bit time to keep the run short.
`timescale 1ns/1ns
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("wrong value %s exp %h got %h", nm, e, g); \
    end \
  end

module tb_lsip_port;
  localparam logic [6:0] DEV = 7'h44;
  logic        mclk, reset_n, conv_done, fault_high, fault_low;
  logic        scl, host_low, sda_oe, sda_out, int_pin, hs_mode;
  logic [6:0]  addr_strap;
  logic [15:0] conv_result, cfg_word, low_limit, high_limit;
  logic        k;
  logic [7:0]  d;
  logic [8:0]  r;
  wire         sda = !(host_low || sda_oe);
  int          n_mismatch = 0;
  int          cmp_count = 0;

  lsip_port u_lsip_port (.mclk(mclk), .reset_n(reset_n), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap(addr_strap), .conv_done(conv_done),
    .conv_result(conv_result), .fault_high(fault_high),
    .fault_low(fault_low), .int_pin(int_pin), .hs_mode(hs_mode),
    .cfg_word(cfg_word), .low_limit(low_limit), .high_limit(high_limit));
  lsip_bus_host u_lsip_bus_host (.scl(scl), .sda_low(host_low), .sda(sda));

  ////////////////////////////////////////////////////////////////////////////
  task automatic put(input logic [7:0] b);
    logic [8:0] a;
    u_lsip_bus_host.xfer({b, 1'b1}, a);
    `CHK("ack", 1'b0, a[0])
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    u_lsip_bus_host.start();
    put({DEV, 1'b0});
    put(p);
    put(v[15:8]);
    put(v[7:0]);
    u_lsip_bus_host.stop();
  endtask

  task automatic setp(input logic [7:0] p);
    u_lsip_bus_host.start();
    put({DEV, 1'b0});
    put(p);
    u_lsip_bus_host.stop();
  endtask

  task automatic rd(input logic [15:0] e);
    logic [8:0] h;
    logic [8:0] l;
    u_lsip_bus_host.start();
    put({DEV, 1'b1});
    u_lsip_bus_host.xfer(9'h1fe, h);
    u_lsip_bus_host.xfer(9'h1ff, l);
    u_lsip_bus_host.stop();
    `CHK("read", e, {h[8:1], l[8:1]})
  endtask

  task automatic ara(input logic [7:0] w);
    logic [8:0] a;
    u_lsip_bus_host.start();
    u_lsip_bus_host.xfer({lsip_pkg::ARA_ADDR, 2'b11}, a);
    u_lsip_bus_host.xfer({w, 1'b1}, r);
    u_lsip_bus_host.stop();
    k = a[0];
    d = r[8:1];
  endtask

  task automatic conv(input logic h, input logic l);
    @(posedge mclk);
    conv_done <= 1'b1;
    fault_high <= h;
    fault_low <= l;
    conv_result <= conv_result + 16'h0101;
    @(posedge mclk);
    conv_done <= 1'b0;
    repeat (3) @(posedge mclk);
    #2;
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // About 0.5 ms of bus traffic expected
  initial
  begin
    #900_000;
    n_mismatch++;
    final_report();
  end

  initial
  begin
    {reset_n, conv_done, fault_high, fault_low} = 4'h0;
    conv_result = 16'h0000;
    addr_strap = DEV;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (5) @(posedge mclk);
    #2;
    rd(lsip_pkg::RESULT_RESET);
    `CHK("sda out", 1'b0, sda_out)
    setp(lsip_pkg::PTR_CONFIG);
    rd(lsip_pkg::CFG_RESET);
    wr(lsip_pkg::PTR_CONFIG, 16'hcc00);
    `CHK("cfg", 16'hcc00, cfg_word)
    conv(1'b0, 1'b1);
    `CHK("int", 1'b1, int_pin)
    wr(lsip_pkg::PTR_LOW, 16'hc000);
    `CHK("low", 16'hc000, low_limit)
    conv(1'b1, 1'b0);
    `CHK("st", 3'b110, cfg_word[7:5])
    `CHK("int", 1'b0, int_pin)
    conv(1'b0, 1'b1);
    `CHK("st", 3'b101, cfg_word[7:5])
    conv(1'b0, 1'b0);
    `CHK("st", 3'b101, cfg_word[7:5])
    setp(lsip_pkg::PTR_CONFIG);
    rd(16'hcca0);
    `CHK("int", 1'b1, int_pin)
    rd(16'hcc20);
    conv(1'b0, 1'b0);
    wr(lsip_pkg::PTR_CONFIG, 16'hc800);
    `CHK("cfg", 16'hc8a0, cfg_word)
    `CHK("int", 1'b0, int_pin)
    wr(lsip_pkg::PTR_CONFIG, 16'hcc08);
    `CHK("cfg", 16'hcc28, cfg_word)
    `CHK("int", 1'b0, int_pin)
    conv(1'b0, 1'b0);
    ara(8'hff);
    `CHK("ara ack", 1'b1, k)
    `CHK("int", 1'b1, int_pin)
    `CHK("st", 3'b101, cfg_word[7:5])
    wr(lsip_pkg::PTR_CONFIG, 16'hcc18);
    conv(1'b1, 1'b0);
    ara(8'h00);
    `CHK("ara ack", 1'b0, k)
    `CHK("int", 1'b1, int_pin)
    ara(8'hff);
    `CHK("ara addr", {DEV, 1'b1}, d)
    `CHK("int", 1'b0, int_pin)
    `CHK("flags", 2'b11, cfg_word[6:5])
    u_lsip_bus_host.half = 1250;
    u_lsip_bus_host.start();
    u_lsip_bus_host.xfer({lsip_pkg::HS_CODE_TOP, 4'h1}, r);
    `CHK("code ack", 1'b1, r[0])
    for (int i = 0; i < 50 && hs_mode !== 1'b1; i++) @(posedge mclk);
    #2;
    `CHK("hs", 1'b1, hs_mode)
    u_lsip_bus_host.half = 200;
    wr(lsip_pkg::PTR_HIGH, 16'h1234);
    `CHK("high", 16'h1234, high_limit)
    `CHK("hs", 1'b0, hs_mode)
    u_lsip_bus_host.half = 500;
    wr(8'h10, 16'hbeef);
    rd(16'h0000);
    u_lsip_bus_host.start();
    put(lsip_pkg::GC_ADDR);
    put(lsip_pkg::GC_RESET);
    u_lsip_bus_host.stop();
    `CHK("cfg", lsip_pkg::CFG_RESET, cfg_word)
    `CHK("low", lsip_pkg::LOW_RESET, low_limit)
    `CHK("high", lsip_pkg::HIGH_RESET, high_limit)
    final_report();
  end
endmodule // tb_lsip_port

bind lsip_port lsip_port_properties u_lsip_port_properties (
  .mclk(mclk), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap),
  .conv_done(conv_done), .conv_result(conv_result),
  .fault_high(fault_high), .fault_low(fault_low), .int_pin(int_pin),
  .hs_mode(hs_mode), .cfg_word(cfg_word), .low_limit(low_limit),
  .high_limit(high_limit));
